// ===== shared/uirs_pkg.sv
// Package: register map, field positions, reset values and timing constants of the serial port.
package uirs_pkg;
  // Register indices; each register is one aligned word whose byte address is four times its index.
  localparam logic [15:0] ADDR_LINE_STATUS = 16'h4100;
  localparam logic [15:0] ADDR_TRANSMIT_BYTE = 16'h4101;
  localparam logic [15:0] ADDR_RECEIVE_BYTE = 16'h4102;
  localparam logic [15:0] ADDR_FRAME_FORMAT = 16'h4103;
  localparam logic [15:0] ADDR_TRANSFER_CONTROL = 16'h4104;
  localparam logic [15:0] ADDR_INFRARED_EXTENSION = 16'h4105;
  // Offset of each register from the first register index.
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_TXB = 3'h1;
  localparam logic [2:0] IDX_RXB = 3'h2;
  localparam logic [2:0] IDX_FMT = 3'h3;
  localparam logic [2:0] IDX_CTL = 3'h4;
  localparam logic [2:0] IDX_EXT = 3'h5;
  // Status bit positions.
  localparam int ST_TX_EMPTY = 0;
  localparam int ST_RX_READY = 1;
  localparam int ST_TX_BUSY = 2;
  localparam int ST_RX_SECOND = 3;
  localparam int ST_OVERRUN = 4;
  localparam int ST_PARITY = 5;
  localparam int ST_FRAMING = 6;
  // Format bit positions.
  localparam int FMT_EXT_CLK = 0;
  localparam int FMT_TWO_STOP = 1;
  localparam int FMT_ODD_PARITY = 2;
  localparam int FMT_PARITY_EN = 3;
  localparam int FMT_EIGHT_BIT = 4;
  // Control bit positions.
  localparam int CTL_PORT_EN = 0;
  localparam int CTL_RX_THRESH = 1;
  localparam int CTL_TX_IRQ_EN = 4;
  localparam int CTL_RX_IRQ_EN = 5;
  localparam int CTL_ERR_IRQ_EN = 6;
  // Extension bit positions.
  localparam int EXT_IR_MODE = 0;
  localparam int EXT_DET_LSB = 4;
  // Writable masks; reserved bits read zero.
  localparam logic [7:0] FMT_MASK = 8'h1F;
  localparam logic [7:0] CTL_MASK = 8'h73;
  localparam logic [7:0] EXT_MASK = 8'h71;
  localparam logic [7:0] ERR_MASK = 8'h70;
  // Reset values.
  localparam logic [7:0] RST_STATUS = 8'h01;
  localparam logic [7:0] RST_REG = 8'h00;
  // Transfer clock cycles per bit, and the infrared pulse and stretch figures.
  localparam int SCLK_PER_BIT = 16;
  localparam int IR_TX_PULSE = 3;
  localparam int IR_MIN_DET = 2;
  localparam int IR_STRETCH = 16;
  // AHB transfer type code for a non-sequential transfer.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // Receiver and transmitter states.
  typedef enum logic [1:0] {UIRS_IDLE, UIRS_DATA, UIRS_PAR, UIRS_STOP} uirs_state_e;
endpackage : uirs_pkg

// ===== core/uirs_core.sv
// Module: serial port with single interrupt request, infrared coding and status registers.
`timescale 1ns/100ps

// Summary of operation
// - One shared interrupt request output.
// - Buffer-to-shifter sets empty flag; optional pulse.
// - Receive pulse at one or two bytes.
// - Errors set flags, except parity on overrun; optional same-cycle pulse.
// - Extension bit 0 enables infrared coding.
// - Infrared low bit is 3/16 bit pulse.
// - Valid pulse two detect cycles; stretched sixteen.
// - Detect clock is clock over 2^field.
// - Infrared mode reuses all other behaviour.
// - Six byte registers 0x4100 to 0x4105.
// - Error flags cleared only by writing one.
// - Stop bit zero raises framing error.
// - Parity checked on load when enabled.
// - Overrun keeps buffer, discards shifter.
// - Second-byte flag sets, clears on read.
// - Status resets 0x01; buffer flags read-only.
// - Busy flag from load to end of send.
// - Ready flag set on load, cleared empty.
module uirs_core #(
  parameter int DET_SEL_WIDTH = 3
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [16:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SCLK_INT,
  input wire logic SCLK_EXT,
  input wire logic SERIAL_IN,
  output logic SERIAL_OUT,
  output logic IRQ
);
  import uirs_pkg::*;

  // The detection divider tops out at 2^7, so the select must stay three bits.
  if (DET_SEL_WIDTH != 3) begin : g_bad_width
    $error("DET_SEL_WIDTH must be 3");
  end

  // Software registers.
  logic [7:0] fmt, next_fmt;
  logic [7:0] ctl, next_ctl;
  logic [7:0] ext, next_ext;
  logic [7:0] txb, next_txb;
  logic tx_empty, next_tx_empty;
  logic [2:0] err, next_err; // Overrun, parity, framing.
  // Receive FIFO of two bytes.
  logic [7:0] rx_mem [2];
  logic [7:0] next_rx0, next_rx1;
  logic [1:0] rx_cnt, next_rx_cnt;
  // AHB data-phase capture.
  logic wr_pend, next_wr_pend;
  logic [2:0] wr_idx, next_wr_idx;
  logic [31:0] rdata, next_rdata;
  logic irq, next_irq;
  // Transfer clock edge detect; the previous sample is a plain register, not a synchroniser.
  logic sclk_d, next_sclk_d;
  wire sclk_now = fmt[FMT_EXT_CLK] ? SCLK_EXT : SCLK_INT;
  wire tick = sclk_now & ~sclk_d;
  // Transmit state.
  uirs_state_e tx_st, next_tx_st;
  logic [10:0] tx_sh, next_tx_sh;
  logic [3:0] tx_bits, next_tx_bits;
  logic [3:0] tx_ph, next_tx_ph;
  logic tx_line, next_tx_line;
  // Receive state.
  uirs_state_e rx_st, next_rx_st;
  logic [7:0] rx_sh, next_rx_sh;
  logic [3:0] rx_bits, next_rx_bits;
  logic [3:0] rx_ph, next_rx_ph;
  logic rx_par, next_rx_par;
  // Infrared demodulator.
  logic [6:0] det_div, next_det_div;
  logic [1:0] low_run, next_low_run;
  logic [4:0] stretch, next_stretch;
  logic armed, next_armed;
  // Byte address to register offset; unaligned or unmapped words decode as absent.
  function automatic logic [3:0] reg_decode(input logic [16:0] a);
    logic [14:0] off;
    off = a[16:2] - 15'(ADDR_LINE_STATUS);
    reg_decode = (a[1:0] == 2'h0 && off <= 15'(IDX_EXT)) ? {1'b1, off[2:0]} : 4'h0;
  endfunction : reg_decode
  wire ir_on = ext[EXT_IR_MODE];
  wire [2:0] det_sel = ext[EXT_DET_LSB +: 3];
  wire [6:0] det_mask = 7'((8'h01 << det_sel) - 8'h01);
  wire det_tick = (det_div & det_mask) == 7'h00;
  wire rx_line = ir_on ? (stretch == 5'h00) : SERIAL_IN;
  wire [3:0] decoded = reg_decode(HADDR);
  wire take = HSEL & HREADY & (HTRANS == HTRANS_NONSEQ);
  wire rd_rx = take & ~HWRITE & decoded[3] & (decoded[2:0] == IDX_RXB);
  wire load_tx = (tx_st == UIRS_IDLE) & ~tx_empty & ctl[CTL_PORT_EN] & tick;
  // Parity slot of the outgoing frame; it doubles as a stop level when parity is off.
  wire tx_par = fmt[FMT_PARITY_EN] ?
                (^txb[6:0] ^ (fmt[FMT_EIGHT_BIT] & txb[7]) ^ fmt[FMT_ODD_PARITY]) : 1'b1;
  wire [7:0] rx_word = fmt[FMT_EIGHT_BIT] ? rx_sh : {1'b0, rx_sh[7:1]}; // 7-bit data sits high.
  logic rx_done, fr_err, par_err, ovr_err;
  // Zero-wait slave, always OKAY.
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata;
  assign SERIAL_OUT = tx_line;
  assign IRQ = irq;
  // Status read-back.
  function automatic logic [7:0] status_byte(input logic e, input logic [1:0] c,
                                             input logic b, input logic [2:0] f);
    status_byte = {1'b0, f[0], f[1], f[2], c[1], b, c != 2'h0, e};
  endfunction : status_byte
  // same framing: the format register sets the frame in both modes.
  always_comb begin
    next_tx_st = tx_st;
    next_tx_sh = tx_sh;
    next_tx_bits = tx_bits;
    next_tx_ph = tx_ph;
    next_tx_line = tx_line;
    if (!ctl[CTL_PORT_EN]) begin
      next_tx_st = UIRS_IDLE;
      next_tx_line = 1'b1;
    end else if (load_tx) begin
      next_tx_st = UIRS_DATA;
      next_tx_sh = fmt[FMT_EIGHT_BIT] ? {2'b11, tx_par, txb} : {3'b111, tx_par, txb[6:0]};
      next_tx_bits = 4'(1 + 7 + fmt[FMT_EIGHT_BIT] + fmt[FMT_PARITY_EN] + 1
                        + fmt[FMT_TWO_STOP]);
      next_tx_ph = 4'h0;
      next_tx_line = 1'b0;
    end else if (tx_st != UIRS_IDLE && tick) begin
      next_tx_ph = tx_ph + 4'h1;
      if (tx_ph == 4'(SCLK_PER_BIT - 1)) begin
        next_tx_bits = tx_bits - 4'h1;
        next_tx_sh = {1'b1, tx_sh[10:1]};
        if (tx_bits == 4'h1) begin
          next_tx_st = UIRS_IDLE;
          next_tx_line = 1'b1;
        end else begin
          next_tx_line = tx_sh[0];
        end
      end
      if (ir_on && tx_ph == 4'(IR_TX_PULSE - 1) && tx_ph != 4'(SCLK_PER_BIT - 1)) begin
        next_tx_line = 1'b1;
      end
    end
  end
  // Receiver: samples mid-bit and checks parity and stop on completion.
  always_comb begin
    next_rx_st = rx_st;
    next_rx_sh = rx_sh;
    next_rx_bits = rx_bits;
    next_rx_ph = rx_ph;
    next_rx_par = rx_par;
    rx_done = 1'b0;
    fr_err = 1'b0;
    par_err = 1'b0;
    if (!ctl[CTL_PORT_EN]) begin
      next_rx_st = UIRS_IDLE;
    end else if (tick) begin
      next_rx_ph = rx_ph + 4'h1;
      case (rx_st)
        UIRS_IDLE: begin
          next_rx_ph = 4'h0;
          if (!rx_line) begin
            next_rx_st = UIRS_DATA;
            next_rx_bits = 4'h0;
            next_rx_ph = 4'h1;
          end
        end
        UIRS_DATA: begin
          if (rx_ph == 4'(SCLK_PER_BIT / 2 - 1) && rx_bits != 4'h0) begin
            next_rx_sh = {rx_line, rx_sh[7:1]};
          end
          if (rx_ph == 4'(SCLK_PER_BIT - 1)) begin
            next_rx_bits = rx_bits + 4'h1;
            if (rx_bits == (fmt[FMT_EIGHT_BIT] ? 4'h8 : 4'h7)) begin
              next_rx_st = fmt[FMT_PARITY_EN] ? UIRS_PAR : UIRS_STOP;
            end
          end
        end
        UIRS_PAR: begin
          if (rx_ph == 4'(SCLK_PER_BIT / 2 - 1)) begin
            next_rx_par = rx_line;
          end
          if (rx_ph == 4'(SCLK_PER_BIT - 1)) begin
            next_rx_st = UIRS_STOP;
          end
        end
        UIRS_STOP: begin
          // Only the first stop bit is checked; the second is idle time.
          if (rx_ph == 4'(SCLK_PER_BIT / 2 - 1)) begin
            next_rx_st = UIRS_IDLE;
            rx_done = 1'b1;
            fr_err = ~rx_line;
            par_err = fmt[FMT_PARITY_EN] &
                      ((^rx_sh[7:1] ^ (fmt[FMT_EIGHT_BIT] & rx_sh[0]) ^ rx_par)
                       != fmt[FMT_ODD_PARITY]);
          end
        end
        default: next_rx_st = UIRS_IDLE;
      endcase
    end
  end
  // Infrared demodulator: qualify lows on detect ticks, stretch valid ones.
  always_comb begin
    next_det_div = det_div + 7'h01;
    next_low_run = low_run;
    next_stretch = stretch;
    next_armed = armed;
    if (det_tick) begin
      if (SERIAL_IN) begin
        next_low_run = 2'h0;
        next_armed = 1'b1;
      end else if (low_run != 2'(IR_MIN_DET)) begin
        next_low_run = low_run + 2'h1;
      end
    end
    if (armed && low_run == 2'(IR_MIN_DET) && ir_on) begin
      next_stretch = 5'(IR_STRETCH);
      next_armed = 1'b0;
    end else if (stretch != 5'h00 && tick) begin
      next_stretch = stretch - 5'h01;
    end
  end
  // Registers, buffers, flags and the interrupt pulse.
  always_comb begin
    logic [7:0] w;
    logic [7:0] clr;
    w = HWDATA[7:0];
    clr = 8'h00;
    ovr_err = 1'b0;
    next_fmt = fmt;
    next_ctl = ctl;
    next_ext = ext;
    next_txb = txb;
    next_tx_empty = tx_empty;
    next_err = err;
    next_rx0 = rx_mem[0];
    next_rx1 = rx_mem[1];
    next_rx_cnt = rx_cnt;
    next_wr_pend = take & HWRITE & decoded[3];
    next_wr_idx = decoded[2:0];
    next_rdata = 32'h0000_0000;
    next_irq = 1'b0;
    next_sclk_d = sclk_now;
    if (take && !HWRITE && decoded[3]) begin
      case (decoded[2:0])
        IDX_STATUS: next_rdata = {24'h0, status_byte(tx_empty, rx_cnt, tx_st != UIRS_IDLE, err)};
        IDX_TXB: next_rdata = {24'h0, txb};
        IDX_RXB: next_rdata = {24'h0, rx_mem[0]};
        IDX_FMT: next_rdata = {24'h0, fmt};
        IDX_CTL: next_rdata = {24'h0, ctl};
        IDX_EXT: next_rdata = {24'h0, ext};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    if (rd_rx && rx_cnt != 2'h0) begin
      next_rx0 = rx_mem[1];
      next_rx_cnt = rx_cnt - 2'h1;
    end
    if (wr_pend) begin
      case (wr_idx)
        IDX_STATUS: clr = w & ERR_MASK;
        IDX_TXB: begin
          next_txb = w;
          next_tx_empty = 1'b0;
        end
        IDX_FMT: next_fmt = w & FMT_MASK;
        IDX_CTL: next_ctl = w & CTL_MASK;
        IDX_EXT: next_ext = w & EXT_MASK;
        default: next_txb = txb;
      endcase
    end
    next_err = err & ~{clr[ST_OVERRUN], clr[ST_PARITY], clr[ST_FRAMING]};
    // Disabling the port flushes the transmit buffer.
    if (!next_ctl[CTL_PORT_EN]) begin
      next_tx_empty = 1'b1;
    end
    if (load_tx) begin
      next_tx_empty = 1'b1;
      next_irq = ctl[CTL_TX_IRQ_EN];
    end
    if (rx_done) begin
      if (next_rx_cnt == 2'h2) begin
        ovr_err = 1'b1;
      end else begin
        if (next_rx_cnt == 2'h0) begin
          next_rx0 = rx_word;
        end else begin
          next_rx1 = rx_word;
        end
        next_rx_cnt = next_rx_cnt + 2'h1;
        if (ctl[CTL_RX_IRQ_EN] && (next_rx_cnt == (ctl[CTL_RX_THRESH] ? 2'h2 : 2'h1))) begin
          next_irq = 1'b1;
        end
      end
    end
    next_err = next_err | {ovr_err, par_err & ~ovr_err, fr_err};
    if ((ovr_err | par_err | fr_err) && ctl[CTL_ERR_IRQ_EN]) begin
      next_irq = 1'b1;
    end
  end

  // Register update; synchronous reset to documented values.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      fmt <= RST_REG;
      ctl <= RST_REG;
      ext <= RST_REG;
      txb <= RST_REG;
      tx_empty <= RST_STATUS[ST_TX_EMPTY];
      err <= 3'h0;
      rx_mem[0] <= RST_REG;
      rx_mem[1] <= RST_REG;
      rx_cnt <= 2'h0;
      wr_pend <= 1'b0;
      wr_idx <= 3'h0;
      rdata <= 32'h0000_0000;
      irq <= 1'b0;
      sclk_d <= 1'b0;
      tx_st <= UIRS_IDLE;
      tx_sh <= 11'h7FF;
      tx_bits <= 4'h0;
      tx_ph <= 4'h0;
      tx_line <= 1'b1;
      rx_st <= UIRS_IDLE;
      rx_sh <= 8'h00;
      rx_bits <= 4'h0;
      rx_ph <= 4'h0;
      rx_par <= 1'b0;
      det_div <= 7'h00;
      low_run <= 2'h0;
      stretch <= 5'h00;
      armed <= 1'b1;
    end else begin
      fmt <= next_fmt;
      ctl <= next_ctl;
      ext <= next_ext;
      txb <= next_txb;
      tx_empty <= next_tx_empty;
      err <= next_err;
      rx_mem[0] <= next_rx0;
      rx_mem[1] <= next_rx1;
      rx_cnt <= next_rx_cnt;
      wr_pend <= next_wr_pend;
      wr_idx <= next_wr_idx;
      rdata <= next_rdata;
      irq <= next_irq;
      sclk_d <= next_sclk_d;
      tx_st <= next_tx_st;
      tx_sh <= next_tx_sh;
      tx_bits <= next_tx_bits;
      tx_ph <= next_tx_ph;
      tx_line <= next_tx_line;
      rx_st <= next_rx_st;
      rx_sh <= next_rx_sh;
      rx_bits <= next_rx_bits;
      rx_ph <= next_rx_ph;
      rx_par <= next_rx_par;
      det_div <= next_det_div;
      low_run <= next_low_run;
      stretch <= next_stretch;
      armed <= next_armed;
    end
  end
endmodule : uirs_core

// ===== dv/uirs_core_monitor.sv
// Checker for bus answers, reserved read bits, reset levels and request pulse width.
`timescale 1ns/100ps
module uirs_core_monitor
  import uirs_pkg::*;
#(
  parameter int DET_SEL_WIDTH = 3
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [16:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic SERIAL_OUT,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // High while a read address phase is taken; idx is the register index of its word.
  logic rd_a;
  logic [15:0] idx;
  assign rd_a = HSEL && HREADY && HTRANS == HTRANS_NONSEQ && !HWRITE;
  assign idx = {1'b0, HADDR[16:2]};
  // Read address phase to one register.
  sequence s_rd(a);
    rd_a && HADDR[1:0] == 2'h0 && idx == a;
  endsequence
  property p_irq_one;
    IRQ |=> !IRQ;
  endproperty
  property p_bus_ok;
    HREADYOUT && !HRESP;
  endproperty
  property p_idle_zero;
    !rd_a |=> HRDATA == 32'h0;
  endproperty
  property p_upper_zero;
    rd_a |=> HRDATA[31:8] == 24'h0;
  endproperty
  property p_unmapped;
    rd_a && (HADDR[1:0] != 2'h0 || idx < ADDR_LINE_STATUS || idx > ADDR_INFRARED_EXTENSION)
      |=> HRDATA == 32'h0;
  endproperty
  property p_status_res;
    s_rd(ADDR_LINE_STATUS) |=> !HRDATA[7] && (!HRDATA[3] || HRDATA[1]);
  endproperty
  property p_fmt_res;
    s_rd(ADDR_FRAME_FORMAT) |=> (HRDATA[7:0] & ~FMT_MASK) == 8'h00;
  endproperty
  property p_ctl_res;
    s_rd(ADDR_TRANSFER_CONTROL) |=> (HRDATA[7:0] & ~CTL_MASK) == 8'h00;
  endproperty
  property p_ext_res;
    s_rd(ADDR_INFRARED_EXTENSION) |=> (HRDATA[7:0] & ~EXT_MASK) == 8'h00;
  endproperty
  // Reset must leave the line idle and the request low.
  property p_rst;
    disable iff (1'b0) RESET |=> SERIAL_OUT && !IRQ;
  endproperty
  a_irq_one: assert property (p_irq_one) else $error("request wider than one clock");
  a_bus_ok: assert property (p_bus_ok) else $error("wait state or error response");
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside read");
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_status_res: assert property (p_status_res) else $error("status bits wrong");
  a_fmt_res: assert property (p_fmt_res) else $error("format reserved bit set");
  a_ctl_res: assert property (p_ctl_res) else $error("control reserved bit set");
  a_ext_res: assert property (p_ext_res) else $error("extension reserved bit set");
  a_rst: assert property (p_rst) else $error("reset levels wrong");
endmodule : uirs_core_monitor

bind uirs_core uirs_core_monitor #(.DET_SEL_WIDTH(DET_SEL_WIDTH)) mon_u (.CLK(CLK),
  .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .SERIAL_OUT(SERIAL_OUT), .IRQ(IRQ));

// ===== dv/uirs_line_model.sv
// Remote serial device: sends frames to the port and decodes what the port sends.
`timescale 1ns/100ps
module uirs_line_model (
  input wire logic clk,
  input wire logic sclk,
  input wire logic ir,
  input wire logic serial_out,
  output logic serial_in,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output int start_lows
);
  // The line rests high between frames.
  initial begin
    serial_in = 1'b1;
    rx_valid = 1'b0;
    start_lows = 0;
  end
  // One bit of len ticks; in infrared mode a low bit is a three-tick pulse.
  task automatic put_bit(input logic b, input int len);
    for (int t = 0; t < len; t++) begin
      @(posedge sclk);
      @(negedge clk);
      serial_in = ir ? (b | (t >= 3)) : b;
    end
  endtask : put_bit
  // A low stop bit lasts only until the port's mid-bit sample, so its tail is no false start.
  task automatic send(input logic [7:0] d, input logic pe, input logic pb, input logic stp);
    put_bit(1'b0, 16);
    for (int i = 0; i < 8; i++) put_bit(d[i], 16);
    if (pe) put_bit(pb, 16);
    put_bit(stp, stp ? 16 : 8);
    put_bit(1'b1, 16);
  endtask : send
  // Decode by counting low samples per bit window; mid-frame alignment is tolerant.
  always begin : rx_proc
    int n;
    @(negedge serial_out);
    for (int i = -1; i < 8; i++) begin
      n = 0;
      repeat (16) begin
        @(posedge sclk);
        @(negedge clk);
        n += (serial_out === 1'b0);
      end
      if (i < 0) start_lows = n;
      else rx_byte[i] = ir ? (n == 0) : (n < 8);
    end
    rx_valid = 1'b1;
    @(negedge clk);
    rx_valid = 1'b0;
  end
endmodule : uirs_line_model

// ===== dv/uart_irq_infrared_status_tb.sv
// Bench for registers, requests, line errors and infrared coding of the serial port.
`timescale 1ns/100ps
module uart_irq_infrared_status_tb;
  import uirs_pkg::*;
  logic CLK, RESET, HSEL, HWRITE, SCLK_INT, IRQ, SERIAL_IN, SERIAL_OUT;
  logic HREADYOUT, HRESP, ir, rx_ok, rd_ph;
  logic [16:0] HADDR;
  logic [1:0] HTRANS, dv;
  logic [31:0] HWDATA, HRDATA;
  logic [7:0] rx_byte, d;
  wire logic HREADY = HREADYOUT;
  int n_fail, tests_run, n_irq, lows, base;
  logic [31:0] rd_q[$];
  logic [7:0] byte_q[$];
  uirs_core dut_u (.CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SCLK_INT(SCLK_INT), .SCLK_EXT(1'b0),
    .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT), .IRQ(IRQ));
  uirs_line_model lm_u (.clk(CLK), .sclk(SCLK_INT), .ir(ir), .serial_out(SERIAL_OUT),
    .serial_in(SERIAL_IN), .rx_byte(rx_byte), .rx_valid(rx_ok), .start_lows(lows));
  always #20 CLK = ~CLK;
  // Transfer clock at a quarter of the system clock, so one bit is 64 cycles.
  always @(posedge CLK) begin
    dv <= dv + 2'h1;
    SCLK_INT <= dv[1];
  end
  // Read data is taken from the queue at the data-phase edge; requests are counted.
  always @(posedge CLK) begin
    if (rd_ph) chk("read data", rd_q.pop_front(), HRDATA);
    rd_ph <= HSEL && HTRANS == HTRANS_NONSEQ && !HWRITE && HREADYOUT === 1'b1;
    if (IRQ === 1'b1) n_irq <= n_irq + 1;
  end
  always @(posedge rx_ok) chk("line byte", {24'h0, byte_q.pop_front()}, {24'h0, rx_byte});
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One single transfer to register index a, at byte address four times a; bounded waits.
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] wd);
    int k;
    HSEL <= 1'b1;
    HADDR <= {a[14:0], 2'b00};
    HWRITE <= w;
    HTRANS <= HTRANS_NONSEQ;
    for (int p = 0; p < 2; p++) begin
      k = 0;
      do begin
        @(posedge CLK);
        k++;
      end while (HREADYOUT !== 1'b1 && k < 20);
      if (HREADYOUT !== 1'b1) begin
        n_fail++;
        end_sim();
      end
      if (p == 0) begin
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
      end
    end
  endtask : bus
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask : tick
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  initial begin
    {CLK, HSEL, HWRITE, SCLK_INT, ir, rd_ph, HADDR, HTRANS, HWDATA, dv} = '0;
    {n_fail, tests_run, n_irq} = '0;
    RESET = 1'b1;
    void'($urandom(32'hBC9F9797));
    tick(8);
    RESET <= 1'b0;
    for (int i = 0; i < 6; i++) rd(ADDR_LINE_STATUS + 16'(i), {31'h0, i == 0});
    rd(16'h4106, 32'h0);
    bus(1'b1, ADDR_FRAME_FORMAT, 32'hFF);
    rd(ADDR_FRAME_FORMAT, 32'h1F);
    bus(1'b1, ADDR_INFRARED_EXTENSION, 32'hFF);
    rd(ADDR_INFRARED_EXTENSION, 32'h71);
    bus(1'b1, ADDR_INFRARED_EXTENSION, 32'h00);
    bus(1'b1, ADDR_LINE_STATUS, 32'hFF);
    rd(ADDR_LINE_STATUS, 32'h01);
    // Transmit with the empty request on, then two bytes with it off.
    bus(1'b1, ADDR_FRAME_FORMAT, 32'h10);
    bus(1'b1, ADDR_TRANSFER_CONTROL, 32'h11);
    d = 8'($urandom);
    byte_q.push_back(d);
    bus(1'b1, ADDR_TRANSMIT_BYTE, {24'h0, d});
    tick(10);
    rd(ADDR_LINE_STATUS, 32'h05);
    tick(800);
    chk("irq count", 1, n_irq);
    rd(ADDR_LINE_STATUS, 32'h01);
    bus(1'b1, ADDR_TRANSFER_CONTROL, 32'h01);
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      byte_q.push_back(d);
      bus(1'b1, ADDR_TRANSMIT_BYTE, {24'h0, d});
      tick(10);
    end
    rd(ADDR_LINE_STATUS, 32'h04);
    tick(1600);
    chk("irq count", 1, n_irq);
    // Two-byte threshold, then an overrun with the error request off.
    bus(1'b1, ADDR_TRANSFER_CONTROL, 32'h23);
    lm_u.send(8'hA5, 1'b0, 1'b0, 1'b1);
    tick(4);
    chk("irq count", 1, n_irq);
    rd(ADDR_LINE_STATUS, 32'h03);
    lm_u.send(8'h3C, 1'b0, 1'b0, 1'b1);
    tick(4);
    chk("irq count", 2, n_irq);
    rd(ADDR_LINE_STATUS, 32'h0B);
    lm_u.send(8'h81, 1'b0, 1'b0, 1'b1);
    tick(4);
    rd(ADDR_LINE_STATUS, 32'h1B);
    rd(ADDR_RECEIVE_BYTE, 32'hA5);
    rd(ADDR_LINE_STATUS, 32'h13);
    rd(ADDR_RECEIVE_BYTE, 32'h3C);
    rd(ADDR_LINE_STATUS, 32'h11);
    bus(1'b1, ADDR_LINE_STATUS, 32'h00);
    rd(ADDR_LINE_STATUS, 32'h11);
    bus(1'b1, ADDR_LINE_STATUS, 32'h10);
    rd(ADDR_LINE_STATUS, 32'h01);
    // Parity error, then framing error, each with the error request on.
    bus(1'b1, ADDR_TRANSFER_CONTROL, 32'h41);
    bus(1'b1, ADDR_FRAME_FORMAT, 32'h18);
    lm_u.send(8'h5B, 1'b1, ~^8'h5B, 1'b1);
    tick(4);
    chk("irq count", 3, n_irq);
    rd(ADDR_LINE_STATUS, 32'h23);
    rd(ADDR_RECEIVE_BYTE, 32'h5B);
    bus(1'b1, ADDR_LINE_STATUS, 32'h20);
    bus(1'b1, ADDR_FRAME_FORMAT, 32'h10);
    lm_u.send(8'h66, 1'b0, 1'b0, 1'b0);
    tick(4);
    chk("irq count", 4, n_irq);
    rd(ADDR_LINE_STATUS, 32'h43);
    rd(ADDR_RECEIVE_BYTE, 32'h66);
    bus(1'b1, ADDR_LINE_STATUS, 32'h40);
    // Infrared mode is set first, with a detect clock fast enough for the pulses.
    d = {1'b0, 3'($urandom_range(1, 0)), 4'h1};
    bus(1'b1, ADDR_INFRARED_EXTENSION, {24'h0, d});
    rd(ADDR_INFRARED_EXTENSION, {24'h0, d});
    ir = 1'b1;
    bus(1'b1, ADDR_TRANSFER_CONTROL, 32'h01);
    d = 8'($urandom);
    byte_q.push_back(d);
    bus(1'b1, ADDR_TRANSMIT_BYTE, {24'h0, d});
    tick(800);
    chk("pulse ticks", 3, lows);
    lm_u.send(8'hC3, 1'b0, 1'b0, 1'b1);
    tick(4);
    rd(ADDR_LINE_STATUS, 32'h03);
    rd(ADDR_RECEIVE_BYTE, 32'hC3);
    tick(4);
    chk("line bytes left", 32'h0, byte_q.size());
    chk("reads left", 32'h0, rd_q.size());
    end_sim();
  end
endmodule : uart_irq_infrared_status_tb
